// [prio_map.svh]
// register offsets, field positions and reset values of the priority select block
`ifndef PRIO_MAP_SVH
`define PRIO_MAP_SVH
`define PRIO_ADDR_W        3
`define PRIO_OFF_A         3'h0
`define PRIO_OFF_B         3'h1
`define PRIO_OFF_C         3'h2
`define PRIO_OFF_CTRL      3'h3
`define PRIO_RST_A         8'hff
`define PRIO_RST_B         8'h5f
`define PRIO_RST_C         8'h3f
`define PRIO_MASK_A        8'hff
`define PRIO_MASK_B        8'h5f
`define PRIO_MASK_C        8'h3f
`define PRIO_CTRL_EN_BIT   0
`define PRIO_CTRL_MCU_BIT  1
`define PRIO_PSP_BIT       7
`define PRIO_RST_EN        1'b0
`define PRIO_RST_MCU       1'b1
`define PRIO_B_CMP_BIT     6
`define PRIO_B_LOW_MSB     4
`define PRIO_C_TOP_MSB     5
`define PRIO_SRC_W         20
`define PRIO_VEC_B_LSB     8
`define PRIO_VEC_C_LSB     14
`define PRIO_ZERO_BYTE     8'h00
`define PRIO_ZERO_WORD     32'h0000_0000
`endif

// [prio_pkg.sv]
// types shared by the priority select block
package prio_pkg;
	typedef struct packed {
		logic [2:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} avl_req_s;
	typedef logic [19:0] prio_vec_t;
endpackage : prio_pkg

// [prio_byte_reg.sv]
// one byte of priority bits with write mask and reset value
`timescale 1ns/100ps
module prio_byte_reg #(
	parameter logic [7:0] RESET_VAL = 8'hff,
	parameter logic [7:0] IMPL_MASK = 8'hff
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] value
);
	logic [7:0] value_reg;
	logic [7:0] value_next;

	always_comb begin
		value_next = value_reg;
		if (wr_en) begin
			// unimplemented bits never store, so they read back zero
			value_next = wr_data & IMPL_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			value_reg <= RESET_VAL;
		end else if (ce) begin
			value_reg <= value_next;
		end
	end

	assign value = value_reg;
endmodule : prio_byte_reg

// [peripheral_irq_priority_select.sv]
// peripheral interrupt priority select registers with avalon-mm slave
`timescale 1ns/100ps
`include "prio_map.svh"
module peripheral_irq_priority_select (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	input  wire logic                 large_pkg,
	input  wire logic [2:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	output prio_pkg::prio_vec_t       src_high_prio,
	output logic                      two_level_mode
);
	import prio_pkg::*;

	// ******************************************
	// bus request and register write strobes
	// ******************************************
	avl_req_s   req;
	logic       ack_reg;
	logic       ack_next;
	logic       wait_reg;
	logic       wait_next;
	logic       wr_go;
	logic       wr_a;
	logic       wr_b;
	logic       wr_c;
	logic [7:0] prio_a;
	logic [7:0] prio_b;
	logic [7:0] prio_c;
	logic       levels_en_reg;
	logic       levels_en_next;
	logic       mcu_mode_reg;
	logic       mcu_mode_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	prio_vec_t  vec_reg;
	prio_vec_t  vec_next;
	prio_vec_t  raw_vec;

	assign req = '{address: avs_address, read: avs_read, write: avs_write,
		writedata: avs_writedata, byteenable: avs_byteenable};

	// one wait cycle per access: the request is answered the cycle after it is seen
	assign wr_go = req.write && ack_reg && req.byteenable[0];
	assign wr_a  = wr_go && (req.address == `PRIO_OFF_A);
	assign wr_b  = wr_go && (req.address == `PRIO_OFF_B);
	assign wr_c  = wr_go && (req.address == `PRIO_OFF_C);

	// lanes 31:8 are dropped: software only ever writes the low byte
	prio_byte_reg #(
		.RESET_VAL(`PRIO_RST_A),
		.IMPL_MASK(`PRIO_MASK_A)
	) u_reg_a (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.wr_en  (wr_a),
		.wr_data(req.writedata[7:0]),
		.value  (prio_a)
	);

	prio_byte_reg #(
		.RESET_VAL(`PRIO_RST_B),
		.IMPL_MASK(`PRIO_MASK_B)
	) u_reg_b (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.wr_en  (wr_b),
		.wr_data(req.writedata[7:0]),
		.value  (prio_b)
	);

	prio_byte_reg #(
		.RESET_VAL(`PRIO_RST_C),
		.IMPL_MASK(`PRIO_MASK_C)
	) u_reg_c (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.wr_en  (wr_c),
		.wr_data(req.writedata[7:0]),
		.value  (prio_c)
	);

	// ******************************************
	// bus answer, control register
	// ******************************************
	always_comb begin
		ack_next       = (req.read || req.write) && !ack_reg;
		wait_next      = !ack_next;
		levels_en_next = levels_en_reg;
		mcu_mode_next  = mcu_mode_reg;
		rdata_next     = rdata_reg;
		if (wr_go && (req.address == `PRIO_OFF_CTRL)) begin
			levels_en_next = req.writedata[`PRIO_CTRL_EN_BIT];
			mcu_mode_next  = req.writedata[`PRIO_CTRL_MCU_BIT];
		end
		// read data latched as the request is seen, so it stands through the answer cycle
		if (req.read && !ack_reg) begin
			case (req.address)
				`PRIO_OFF_A:    rdata_next = {24'h00_0000, prio_a};
				`PRIO_OFF_B:    rdata_next = {24'h00_0000, prio_b};
				`PRIO_OFF_C:    rdata_next = {24'h00_0000, prio_c};
				`PRIO_OFF_CTRL: rdata_next = {30'h0000_0000, mcu_mode_reg, levels_en_reg};
				default:        rdata_next = `PRIO_ZERO_WORD;
			endcase
		end
	end

	// waitrequest has a flop of its own so the pin never passes an inverter
	// limitation: a write answered while ce is low is lost, so ce may only drop between transfers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_reg       <= 1'b0;
			wait_reg      <= 1'b1;
			levels_en_reg <= `PRIO_RST_EN;
			mcu_mode_reg  <= `PRIO_RST_MCU;
			rdata_reg     <= `PRIO_ZERO_WORD;
		end else if (ce) begin
			ack_reg       <= ack_next;
			wait_reg      <= wait_next;
			levels_en_reg <= levels_en_next;
			mcu_mode_reg  <= mcu_mode_next;
			rdata_reg     <= rdata_next;
		end
	end

	// ******************************************
	// gated priority vector
	// ******************************************
	always_comb begin
		raw_vec = {prio_c[`PRIO_C_TOP_MSB:0], prio_b[`PRIO_B_CMP_BIT], prio_b[`PRIO_B_LOW_MSB:0], prio_a};
		// parallel port bit only counts in microcontroller mode on the larger parts
		if (large_pkg && !mcu_mode_reg) begin
			raw_vec[`PRIO_PSP_BIT] = 1'b0;
		end
		// single-level mode: no bit may steer anything, all read as high
		vec_next = levels_en_reg ? raw_vec : '1;
	end

	// reset acts regardless of the clock enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vec_reg <= '1;
		end else if (ce) begin
			vec_reg <= vec_next;
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign src_high_prio   = vec_reg;
	assign two_level_mode  = levels_en_reg;

	// ******************************************
	// assertions
	// ******************************************
	AST_SINGLE_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !levels_en_reg) |=> (src_high_prio == '1)) else $error("priority vector not all high in single level");
	AST_VEC_FOLLOWS_A: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && levels_en_reg) |=> (src_high_prio[6:0] == $past(prio_a[6:0]))) else $error("vector low bits wrong");
	AST_PSP_GATED: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && levels_en_reg && large_pkg && !mcu_mode_reg) |=> !src_high_prio[7]) else $error("parallel port bit not gated");
	AST_B_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		(prio_b[7] == 1'b0) && (prio_b[5] == 1'b0)) else $error("register b hole not zero");
	AST_C_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		prio_c[7:6] == 2'b00) else $error("register c top bits not zero");
	AST_WRITE_A: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && wr_a) |=> (prio_a == $past(req.writedata[7:0]))) else $error("register a write lost");
	AST_WRITE_B: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && wr_b) |=> (prio_b == ($past(req.writedata[7:0]) & `PRIO_MASK_B))) else $error("register b write wrong");
	AST_WRITE_C: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && wr_c) |=> (prio_c == ($past(req.writedata[7:0]) & `PRIO_MASK_C))) else $error("register c write wrong");
	AST_LOW_PRIO: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && levels_en_reg && !prio_b[3]) |=> !src_high_prio[11]) else $error("bus collision zero not low");
	AST_MODE_OUT: assert property (@(posedge clk) disable iff (!rst_n)
		two_level_mode == levels_en_reg) else $error("mode output mismatch");
	AST_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && (avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest) else $error("no answer");
	AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !avs_waitrequest) |=> avs_waitrequest) else $error("answer stood longer than one cycle");
	AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
		!ce |=> ($stable(src_high_prio) && $stable(avs_waitrequest))) else $error("state moved with ce low");
	AST_VEC_FOLLOWS_B: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && levels_en_reg) |=>
		(src_high_prio[13:8] == $past({prio_b[6], prio_b[4:0]}))) else $error("vector b bits wrong");
	AST_VEC_FOLLOWS_C: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && levels_en_reg) |=>
		(src_high_prio[19:14] == $past(prio_c[5:0]))) else $error("vector c bits wrong");
	AST_PSP_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && levels_en_reg && (!large_pkg || mcu_mode_reg)) |=>
		(src_high_prio[7] == $past(prio_a[7]))) else $error("parallel port bit wrongly gated");
	AST_READ_A: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && avs_read && avs_waitrequest && (avs_address == `PRIO_OFF_A)) |=>
		(avs_readdata == {24'h00_0000, $past(prio_a)})) else $error("register a read wrong");
	AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && avs_read && avs_waitrequest && avs_address[2]) |=>
		(avs_readdata == `PRIO_ZERO_WORD)) else $error("unmapped read not zero");
	AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && wr_go && (req.address == `PRIO_OFF_CTRL)) |=>
		(two_level_mode == $past(req.writedata[`PRIO_CTRL_EN_BIT]))) else $error("enable write lost");

	// ******************************************
	// covers
	// ******************************************

	COV_WRITE_A: cover property (@(posedge clk) disable iff (!rst_n) ce && wr_a);
	COV_READ_C: cover property (@(posedge clk) disable iff (!rst_n) ce && avs_read && !avs_waitrequest
		&& avs_address == `PRIO_OFF_C);
	COV_ENABLE: cover property (@(posedge clk) disable iff (!rst_n) $rose(levels_en_reg));
	COV_PSP: cover property (@(posedge clk) disable iff (!rst_n) large_pkg && !mcu_mode_reg && levels_en_reg);
endmodule : peripheral_irq_priority_select

// [peripheral_irq_priority_select_tb_top.sv]
// self-checking bench of the peripheral priority select block
`timescale 1ns/100ps
`include "prio_map.svh"
module peripheral_irq_priority_select_tb_top;
	import prio_pkg::*;
	// ****************
	// signals and model
	// ****************
	logic        clk, rst_n, ce, large_pkg, avs_read, avs_write, avs_waitrequest, two_level_mode;
	logic [2:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, r;
	logic [3:0]  avs_byteenable;
	prio_vec_t   src_high_prio;
	int          fail_count, cmp_count, seed;
	logic [7:0]  mdl [0:3];
	logic [7:0]  msk [0:3];
	peripheral_irq_priority_select peripheral_irq_priority_select_i (.clk(clk), .rst_n(rst_n), .ce(ce),
		.large_pkg(large_pkg), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .src_high_prio(src_high_prio), .two_level_mode(two_level_mode));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ****************
	// tasks and expectations
	// ****************
	function automatic prio_vec_t exp_vec(input logic lp);
		prio_vec_t v;
		v = {mdl[2][5:0], mdl[1][6], mdl[1][4:0], mdl[0]};
		if (lp && !mdl[3][1]) v[7] = 1'b0;
		if (!mdl[3][0]) v = '1;
		return v;
	endfunction : exp_vec
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// request held until the edge where waitrequest is sampled low
	task automatic bus(input logic wr, input logic [2:0] adr, input logic [31:0] wd, input logic [3:0] be);
		int n;
		avs_address <= adr;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			fail_count++;
			$display("[FAIL] %0t bus answer timed out", $time);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (wr && be[0] && adr < 3'h4) mdl[adr[1:0]] = wd[7:0] & msk[adr[1:0]];
		// idle edge so the next call never reassigns a strobe in this time step
		@(posedge clk);
	endtask : bus
	task automatic sweep();
		for (int a = 0; a < 8; a++) begin
			bus(1'b0, a[2:0], 32'h0, 4'hf);
			chk(rd, (a < 4) ? {24'h0, mdl[a[1:0]]} : 32'h0, "readback");
		end
		chk({12'h0, src_high_prio}, {12'h0, exp_vec(large_pkg)}, "priority vector");
		chk({31'h0, two_level_mode}, {31'h0, mdl[3][0]}, "two level mode");
	endtask : sweep
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	// ****************
	// main sequence
	// ****************
	initial begin
		seed = 20414;
		{large_pkg, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
		ce = 1'b1;
		rst_n = 1'b0;
		msk = '{`PRIO_MASK_A, `PRIO_MASK_B, `PRIO_MASK_C, 8'h03};
		mdl = '{`PRIO_RST_A, `PRIO_RST_B, `PRIO_RST_C, 8'h02};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		sweep();
		// all low priority, large part outside microcontroller mode
		for (int a = 0; a < 3; a++) bus(1'b1, a[2:0], 32'h0, 4'h1);
		large_pkg <= 1'b1;
		bus(1'b1, `PRIO_OFF_CTRL, 32'h1, 4'h1);
		sweep();
		// lane 0 disabled, so the write must be dropped
		bus(1'b1, `PRIO_OFF_A, 32'hff, 4'he);
		bus(1'b1, 3'h5, 32'hff, 4'hf);
		sweep();
		// register a all high: the parallel port bit must stay low on a large part
		bus(1'b1, `PRIO_OFF_A, 32'hff, 4'h1);
		sweep();
		// a low clock enable must hold the vector while the strap moves
		large_pkg <= 1'b0;
		repeat (2) @(posedge clk);
		chk({12'h0, src_high_prio}, {12'h0, exp_vec(1'b0)}, "small part vector");
		ce <= 1'b0;
		large_pkg <= 1'b1;
		repeat (3) @(posedge clk);
		chk({12'h0, src_high_prio}, {12'h0, exp_vec(1'b0)}, "frozen vector");
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk({12'h0, src_high_prio}, {12'h0, exp_vec(1'b1)}, "thawed vector");
		// random traffic, unmapped places included
		repeat (40) begin
			r = $random(seed);
			large_pkg <= r[8];
			bus(1'b1, r[2:0], {24'h0, r[23:16]}, r[7:4] | 4'h1);
			sweep();
		end
		// second reset in mid-run brings every register back to its reset value
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		mdl = '{`PRIO_RST_A, `PRIO_RST_B, `PRIO_RST_C, 8'h02};
		sweep();
		test_done();
	end
	// limit well above the ~1230 cycles the sequence needs
	initial begin
		#(50 * 20000);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end
endmodule : peripheral_irq_priority_select_tb_top
